/* File: core/vimap_pkg.sv */
/*
  Constants shared by the virtual input mapper core.
  Assumes a single 40 MHz system clock and a synchronous active-high reset.
*/
package vimap_pkg;
  localparam int VIMAP_NUM_INPUTS = 20;
  localparam int VIMAP_NUM_W = 16;
  localparam int VIMAP_IDX_W = 5;
  localparam logic [VIMAP_NUM_INPUTS-1:0] VIMAP_POLARITY_DEFAULT = 20'h00000;
  localparam logic [VIMAP_NUM_W-1:0] VIMAP_OFFSET_DEFAULT = 16'h0000;
  localparam logic VIMAP_ENABLE_DEFAULT = 1'b0;
  localparam logic [VIMAP_NUM_W-1:0] VIMAP_FIRST_PIN = 16'h0001;
  localparam logic [1:0] VIMAP_SETTLE_EDGES = 2'h3;
endpackage

/* File: core/vimap_core.sv */
/*
  Virtual input mapper: synchronises twenty input pins, resolves their polarity,
  and reports each state change as a virtual input number with its on/off state.
  Assumes the downstream consumer accepts reports with a valid/ready handshake.
*/
`timescale 1ns/1ps
module vimap_core
  import vimap_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  // configuration, latched only at reset
  input wire logic cfg_enable,
  input wire logic [VIMAP_NUM_W-1:0] cfg_virtual_offset,
  input wire logic [VIMAP_NUM_INPUTS-1:0] cfg_active_low,
  // input pins
  input wire logic [VIMAP_NUM_INPUTS-1:0] general_input,
  // report stream
  output logic rpt_valid,
  input wire logic rpt_ready,
  output logic [VIMAP_NUM_W-1:0] rpt_virtual_input_number,
  output logic rpt_state,
  // status
  output logic [VIMAP_NUM_INPUTS-1:0] input_state,
  output logic monitor_active
);

  // latched configuration
  logic enable_q;
  logic [VIMAP_NUM_W-1:0] offset_q;
  logic [VIMAP_NUM_INPUTS-1:0] active_low_q;

  // pin synchroniser stages
  logic [VIMAP_NUM_INPUTS-1:0] sync1_q;
  logic [VIMAP_NUM_INPUTS-1:0] sync2_q;

  // resolved and tracked pin state
  logic [VIMAP_NUM_INPUTS-1:0] resolved;
  logic [VIMAP_NUM_INPUTS-1:0] state_q;
  logic [VIMAP_NUM_INPUTS-1:0] reported_q;
  logic [VIMAP_NUM_INPUTS-1:0] fresh_q;
  logic [VIMAP_NUM_INPUTS-1:0] pending;
  logic [VIMAP_NUM_INPUTS-1:0] take_pin;

  // settling after reset
  logic [1:0] settle_q;
  logic primed;

  // report scan and handshake
  logic step;
  logic launch;
  logic accept;
  logic scan_last;
  logic [VIMAP_IDX_W-1:0] scan_q;
  logic [VIMAP_NUM_W-1:0] num_d;
  logic [VIMAP_NUM_W-1:0] num_q;
  logic st_q;
  logic valid_q;

  // tracking past the synchroniser advances only when enabled and not frozen
  assign step = clk_en & enable_q;

  // config captured at reset only, so live edits cannot disturb a running map
  always_ff @(posedge clk) begin
    if (srst) begin
      enable_q <= cfg_enable;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      offset_q <= cfg_virtual_offset;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      active_low_q <= cfg_active_low;
    end
  end

  // first synchroniser stage; read only by the second stage
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_q <= '0;
    end else if (clk_en) begin
      sync1_q <= general_input;
    end
  end

  // second synchroniser stage
  always_ff @(posedge clk) begin
    if (srst) begin
      sync2_q <= '0;
    end else if (clk_en) begin
      sync2_q <= sync1_q;
    end
  end

  // resolved state snapshot, one bit per physical pin
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= '0;
    end else if (step) begin
      state_q <= resolved;
    end
  end

  // pending reports wait until the synchroniser has flushed its reset zeros,
  // otherwise a pin would be reported once with a stale state
  always_ff @(posedge clk) begin
    if (srst) begin
      settle_q <= '0;
    end else if (step && (settle_q != VIMAP_SETTLE_EDGES)) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  assign primed = (settle_q == VIMAP_SETTLE_EDGES);

  // a launch happens only from idle, an accept only while a report stands
  assign launch = step & ~valid_q & pending[scan_q];
  assign accept = step & valid_q & rpt_ready;

  genvar gi;
  generate
    for (gi = 0; gi < VIMAP_NUM_INPUTS; gi++) begin : g_pin
      assign resolved[gi] = sync2_q[gi] ^ active_low_q[gi];

      assign take_pin[gi] = launch & (scan_q == VIMAP_IDX_W'(gi));

      // fresh pins are reported once after reset, on or off alike
      assign pending[gi] = primed & (fresh_q[gi] | (state_q[gi] ^ reported_q[gi]));

      always_ff @(posedge clk) begin
        if (srst) begin
          reported_q[gi] <= 1'b0;
        end else if (take_pin[gi]) begin
          reported_q[gi] <= state_q[gi];
        end
      end

      always_ff @(posedge clk) begin
        if (srst) begin
          fresh_q[gi] <= 1'b1;
        end else if (take_pin[gi]) begin
          fresh_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // round-robin scan; it parks while a report stands, so at most one is in flight
  assign scan_last = (scan_q == VIMAP_IDX_W'(VIMAP_NUM_INPUTS - 1));

  always_ff @(posedge clk) begin
    if (srst) begin
      scan_q <= '0;
    end else if (step && !valid_q) begin
      if (scan_last) begin
        scan_q <= '0;
      end else begin
        scan_q <= scan_q + 1'b1;
      end
    end
  end

  // report valid: set on launch, cleared on accept
  always_ff @(posedge clk) begin
    if (srst) begin
      valid_q <= 1'b0;
    end else if (accept) begin
      valid_q <= 1'b0;
    end else if (launch) begin
      valid_q <= 1'b1;
    end
  end

  // number wraps modulo the offset width; users keep offsets apart
  assign num_d = offset_q + VIMAP_FIRST_PIN + VIMAP_NUM_W'(scan_q);

  always_ff @(posedge clk) begin
    if (srst) begin
      num_q <= '0;
    end else if (launch) begin
      num_q <= num_d;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= 1'b0;
    end else if (launch) begin
      st_q <= state_q[scan_q];
    end
  end

  // outputs
  assign rpt_valid = valid_q & enable_q;

  assign rpt_virtual_input_number = num_q;

  assign rpt_state = st_q;

  assign input_state = state_q;

  assign monitor_active = enable_q;

endmodule

/* File: tb/vimap_core_asserts.sv */
/* port checker for vimap_core; clk_en held high */
`timescale 1ns/1ps
module vimap_core_asserts (input wire logic clk, srst, rpt_valid, rpt_ready, monitor_active, rpt_state,
  input wire logic [15:0] rpt_virtual_input_number, input wire logic [19:0] input_state);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  hold_rpt_a: assert property (rpt_valid && !rpt_ready |=> rpt_valid && $stable(rpt_virtual_input_number))
    else $error("held");
  rpt_gap_a: assert property (rpt_valid && rpt_ready |=> !rpt_valid) else $error("gap");
  hold_state_a: assert property (rpt_valid && !rpt_ready |=> $stable(rpt_state)) else $error("state held");
  off_quiet_a: assert property (!monitor_active |-> !rpt_valid) else $error("quiet");
  act_frozen_a: assert property ($stable(monitor_active)) else $error("frozen");
  change_rpt_a: assert property ($changed(input_state) |-> ##[0:400] rpt_valid) else $error("lost");
endmodule

/* File: tb/vimap_sink.sv */
/* sink model with random stalls; one clock */
`timescale 1ns/1ps
module vimap_sink (input wire logic clk, srst, rpt_valid, rpt_state, input wire logic [15:0] num,
  output logic rpt_ready = 1'b0, output logic [15:0] sum, output int cnt, ons);
  always @(posedge clk) begin
    rpt_ready <= 1'($urandom);
    if (srst) {sum, cnt, ons} <= '0;
    else if (rpt_valid && rpt_ready) {sum, cnt, ons} <= {sum + num, cnt + 1, ons + int'(rpt_state)};
  end
endmodule

/* File: tb/vimap_core_tb.sv */
/* vimap_core bench; needs sink and checker */
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin bad_count++; $display("CHECK FAILED %s %h %h", n, e, a); end end
module vimap_core_tb;
  logic clk = 0, srst = 1, en = 0, rr, rv, ma, rs;
  logic [15:0] off = 0, o = 0, num, sum;
  logic [19:0] pol = 0, p = 0, gin = 0, st;
  int bad_count, checks, cyc, cnt, ons;
  function automatic int exp_ons(logic [19:0] g, logic [19:0] q);
    return $countones(g ^ q);
  endfunction
  always #12.5 clk = ~clk;
  vimap_core uut (.clk, .srst, .clk_en(1'b1), .cfg_enable(en), .cfg_virtual_offset(off), .cfg_active_low(pol),
    .general_input(gin), .rpt_valid(rv), .rpt_ready(rr), .rpt_virtual_input_number(num), .rpt_state(rs),
    .input_state(st), .monitor_active(ma));
  vimap_sink sink (.clk, .srst, .rpt_valid(rv), .rpt_state(rs), .num, .rpt_ready(rr), .sum, .cnt, .ons);
  task automatic report_and_stop;
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 3000) begin bad_count++; report_and_stop(); end
  task automatic boot(logic e);
    @(posedge clk) #2 {srst, en, off, pol, gin} = {1'b1, e, o, p, 20'($urandom)};
    repeat (3) @(posedge clk);
    // config moved after release must not reach the core
    #2 {srst, en, off, pol} = {1'b0, ~e, ~o, ~p};
    repeat (200) @(posedge clk) #2;
  endtask
  initial begin
    void'($urandom(32'h2a68739b));
    boot(1'b0);
    `CHK("quiet", 0, cnt)
    `CHK("idle", 20'h0, st)
    for (int i = 0; i < 3; i++) begin
      o = 16'(i * 16'hfff6);
      p = 20'($urandom);
      boot(1'b1);
      `CHK("count", 20, cnt)
      `CHK("sum", 16'(20 * o + 210), sum)
      `CHK("on", 1'b1, ma)
      `CHK("ons", exp_ons(gin, p), ons)
      repeat (5) begin
        @(posedge clk) #2 gin = 20'($urandom);
        repeat (5) @(posedge clk) #2;
        `CHK("state", gin ^ p, st)
      end
      $display("test %0d done", i);
    end
    report_and_stop();
  end
endmodule
bind vimap_core vimap_core_asserts chk (.clk, .srst, .rpt_valid, .rpt_ready, .monitor_active, .rpt_state,
  .rpt_virtual_input_number, .input_state);
